// *** rtl/srw_pkg.sv ***
package srw_pkg;
    // internal oscillator tick derived from clk
    localparam int OSC_DIV = 4;
    localparam logic [6:0] OSC_DIV_LAST = 7'(OSC_DIV - 1);
    localparam int CNT_W = 24;
    // default lengths in oscillator ticks
    localparam int LONG_OPEN_TICKS = 65535;
    localparam int FILTER_TICKS = 4;
    localparam int POR_DELAY_TICKS = 4096;
    localparam int SHORT_DELAY_TICKS = 512;
    localparam int PERIOD_UNIT_TICKS = 64;
    localparam int PERIOD_FIELD_W = 4;
    localparam logic [PERIOD_FIELD_W-1:0] PERIOD_RESET = 4'h0;

    typedef enum logic [3:0] {
        SRW_RST_HOLD = 4'h1,
        SRW_LONG_OPEN = 4'h2,
        SRW_CLOSED = 4'h4,
        SRW_OPEN = 4'h8
    } srw_state_e;
endpackage

// *** rtl/srw_reset_window_watchdog.sv ***
`timescale 1ns/1ps
// Operation
// [RL1] reset out low on internal-supply UV, regulator-output UV or watchdog failure
// [RL2] internal-supply UV clears the supply-fail bit and all configuration settings
// [RL3] regulator UV longer than filter drives reset low; release after delay
// [RL4] regulator UV reappearing during operation drives reset low again
// [RL5] power-on delay is default; a control bit selects the shorter delay
// [RL6] after reset release enter standby and start a long open window
// [RL7] any reset switches off both low-side switches, sensor supply and LED driver
// [RL8] only a write to the watchdog period field is a trigger
// [RL9] trigger is taken when chip select returns high after the word
// [RL10] period follows the value written to the timing field
// [RL11] valid trigger starts a closed window of half the period
// [RL12] closed window is followed by an open window of half the period
// [RL13] host writes the timing field periodically inside the open window
// [RL14] a service in the open window starts the next closed window at once
// [RL15] missed open window gives watchdog reset, then a long open window
// [RL16] watchdog failure forces standby mode
// [RL17] watchdog reset sets a flag; any later SPI access clears it
// [RL18] low-power modes keep watchdog if requested; stop mode needs low current
// [RL19] window, filter, delay and period lengths are oscillator-tick parameters
module srw_reset_window_watchdog
    import srw_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic internal_supply_undervoltage,
    input wire logic regulator_output_undervoltage,
    input wire logic spiCsn,
    input wire logic spiWordDone,
    input wire logic spiPeriodWrite,
    input wire logic [PERIOD_FIELD_W-1:0] spiPeriodValue,
    input wire logic shortDelaySel,
    input wire logic lowPowerReq,
    input wire logic supervisor_stop_mode,
    input wire logic wdKeepEnable,
    input wire logic ccCurrentBelowThreshold,
    input wire logic low_side_switch_one_req,
    input wire logic low_side_switch_two_req,
    input wire logic sensorSupplyReq,
    input wire logic led_high_side_driver_req,
    output logic resetOut_b,
    output logic supervisor_standby_mode,
    output logic low_side_switch_one,
    output logic low_side_switch_two,
    output logic sensorSupplyOn,
    output logic led_high_side_driver,
    output logic internalSupplyOk,
    output logic wdResetFlag,
    output logic configClear,
    output logic wdActive
);
    srw_state_e state;
    logic [6:0] divCnt;
    logic tick;
    logic [CNT_W-1:0] filtCnt;
    logic ccLow;
    logic [CNT_W-1:0] delayCnt;
    logic [CNT_W-1:0] winCnt;
    logic [PERIOD_FIELD_W-1:0] period;
    logic csnPrev;
    logic armed;
    logic trigger;
    logic accessEnd;
    logic wdFail;
    logic wdEnabled;
    logic anyReset;
    logic [CNT_W-1:0] halfTicks;

    // half period in ticks; field value 0 still gives half a unit
    function automatic logic [CNT_W-1:0] half_of(input logic [PERIOD_FIELD_W-1:0] p);
        half_of = CNT_W'((32'(p) + 32'd1) * 32'(PERIOD_UNIT_TICKS) / 32'd2);
    endfunction

    // reload value for the release delay
    function automatic logic [CNT_W-1:0] delay_load(input logic shortSel);
        delay_load = shortSel ? CNT_W'(SHORT_DELAY_TICKS) : CNT_W'(POR_DELAY_TICKS);
    endfunction

    // a load follows its request only while reset is out and no cause is pending
    function automatic logic load_gate(input logic req, input logic relOut, input logic cause);
        load_gate = req && relOut && !cause;
    endfunction

    assign halfTicks = half_of(period); // [RL10] [RL19]

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            divCnt <= 7'h00;
        end else begin
            divCnt <= (divCnt == OSC_DIV_LAST) ? 7'h00 : divCnt + 7'h01;
        end
    end

    // one-cycle enable standing in for the internal oscillator
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tick <= 1'b0;
        end else begin
            tick <= (divCnt == OSC_DIV_LAST);
        end
    end

    // reset value matches idle csn, so no false access end after reset
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            csnPrev <= 1'b1;
        end else begin
            csnPrev <= spiCsn;
        end
    end

    // trigger on csn rising edge after a completed word with the period field written
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            armed <= 1'b0;
        end else if (accessEnd) begin
            armed <= 1'b0;
        end else if (spiWordDone && spiPeriodWrite) begin
            armed <= 1'b1; // [RL8]
        end
    end
    assign accessEnd = spiCsn && !csnPrev;
    assign trigger = accessEnd && armed; // [RL9]

    // regulator UV filter; short glitches below the filter length are ignored
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            filtCnt <= '0;
        end else if (!regulator_output_undervoltage) begin
            filtCnt <= '0;
        end else if (tick && filtCnt < CNT_W'(FILTER_TICKS)) begin
            filtCnt <= filtCnt + CNT_W'(1);
        end
    end

    // reset value high so the release delay always runs after power-up
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ccLow <= 1'b1;
        end else if (!regulator_output_undervoltage) begin
            ccLow <= 1'b0;
        end else if (tick && filtCnt >= CNT_W'(FILTER_TICKS)) begin
            ccLow <= 1'b1; // [RL3] [RL4]
        end
    end

    assign anyReset = internal_supply_undervoltage || ccLow || wdFail; // [RL1]

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            period <= PERIOD_RESET;
        end else if (internal_supply_undervoltage) begin
            period <= PERIOD_RESET; // [RL2]
        end else if (trigger) begin
            period <= spiPeriodValue; // [RL10]
        end
    end

    // watchdog stays on in low power if requested, or in stop while current is high
    assign wdEnabled = !lowPowerReq || wdKeepEnable ||
        (supervisor_stop_mode && !ccCurrentBelowThreshold); // [RL18]

    assign wdFail = (state == SRW_CLOSED && trigger) ||
        (state == SRW_OPEN && tick && winCnt == '0) ||
        (state == SRW_LONG_OPEN && tick && winCnt == '0 && wdEnabled); // [RL15]

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= SRW_RST_HOLD;
            winCnt <= '0;
        end else begin
            case (state)
                SRW_RST_HOLD: begin
                    if (!anyReset && tick && delayCnt == '0) begin
                        state <= SRW_LONG_OPEN; // [RL6]
                        winCnt <= CNT_W'(LONG_OPEN_TICKS);
                    end
                end
                // a disabled watchdog parks in the long open window
                default: begin
                    if (anyReset) begin
                        state <= SRW_RST_HOLD; // [RL1] [RL15]
                    end else if (!wdEnabled) begin
                        state <= SRW_LONG_OPEN;
                        winCnt <= CNT_W'(LONG_OPEN_TICKS);
                    end else if (trigger) begin
                        state <= SRW_CLOSED; // [RL11] [RL14]
                        winCnt <= half_of(spiPeriodValue);
                    end else if (tick && winCnt != '0) begin
                        winCnt <= winCnt - CNT_W'(1);
                    end else if (tick && state == SRW_CLOSED) begin
                        state <= SRW_OPEN; // [RL12]
                        winCnt <= halfTicks;
                    end
                end
            endcase
        end
    end

    // delay reloads while any cause stands, so it counts from the last one
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            delayCnt <= CNT_W'(POR_DELAY_TICKS);
        end else if (anyReset) begin
            delayCnt <= delay_load(shortDelaySel); // [RL5]
        end else if (state == SRW_RST_HOLD && tick && delayCnt != '0) begin
            delayCnt <= delayCnt - CNT_W'(1); // [RL3]
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wdResetFlag <= 1'b0;
        end else if (wdFail) begin
            wdResetFlag <= 1'b1; // [RL17]
        end else if (accessEnd || internal_supply_undervoltage) begin
            wdResetFlag <= 1'b0; // [RL17]
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            configClear <= 1'b1;
        end else begin
            configClear <= internal_supply_undervoltage; // [RL2]
        end
    end

    // supply-fail bit stays low until the host has accessed the interface once
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            internalSupplyOk <= 1'b0;
        end else if (internal_supply_undervoltage) begin
            internalSupplyOk <= 1'b0; // [RL2]
        end else if (accessEnd) begin
            internalSupplyOk <= 1'b1;
        end
    end

    // reset pin low whenever a cause stands or the release delay still runs
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            resetOut_b <= 1'b0;
        end else begin
            resetOut_b <= (state != SRW_RST_HOLD) && !anyReset; // [RL1]
        end
    end

    // a trigger outside reset hold and outside the closed window takes the block out of standby
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            supervisor_standby_mode <= 1'b1;
        end else if (state == SRW_RST_HOLD || anyReset) begin
            supervisor_standby_mode <= 1'b1; // [RL6] [RL16]
        end else if (trigger) begin
            supervisor_standby_mode <= 1'b0;
        end
    end

    // loads switch on one cycle after resetOut_b rises and off in the same cycle it falls, never ahead of it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            low_side_switch_one <= 1'b0;
        end else begin
            low_side_switch_one <= load_gate(low_side_switch_one_req, resetOut_b, anyReset); // [RL7]
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            low_side_switch_two <= 1'b0;
        end else begin
            low_side_switch_two <= load_gate(low_side_switch_two_req, resetOut_b, anyReset); // [RL7]
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sensorSupplyOn <= 1'b0;
        end else begin
            sensorSupplyOn <= load_gate(sensorSupplyReq, resetOut_b, anyReset); // [RL7]
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            led_high_side_driver <= 1'b0;
        end else begin
            led_high_side_driver <= load_gate(led_high_side_driver_req, resetOut_b, anyReset); // [RL7]
        end
    end

    // a watchdog parked by low power reports inactive
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wdActive <= 1'b0;
        end else begin
            wdActive <= state != SRW_RST_HOLD && wdEnabled; // [RL18]
        end
    end
endmodule

// *** verification/srw_reset_window_watchdog_asserts.sv ***
`timescale 1ns/1ps
module srw_reset_window_watchdog_asserts (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic internal_supply_undervoltage,
    input wire logic regulator_output_undervoltage,
    input wire logic spiCsn,
    input wire logic resetOut_b,
    input wire logic supervisor_standby_mode,
    input wire logic low_side_switch_one,
    input wire logic low_side_switch_two,
    input wire logic sensorSupplyOn,
    input wire logic led_high_side_driver,
    input wire logic internalSupplyOk,
    input wire logic wdResetFlag,
    input wire logic configClear
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    sw_off_a: assert property ((!resetOut_b)[*2] |-> !(low_side_switch_one | low_side_switch_two |
        sensorSupplyOn | led_high_side_driver)) else $error("loads on in reset");
    rel_stby_a: assert property ($rose(resetOut_b) |-> supervisor_standby_mode) else $error("no standby");
    isup_rst_a: assert property (internal_supply_undervoltage |-> ##[1:2] !resetOut_b) else $error("no reset");
    cfg_clr_a: assert property (internal_supply_undervoltage |-> ##[1:2] configClear && !internalSupplyOk)
        else $error("config kept");
    flag_rst_a: assert property ($rose(wdResetFlag) |-> ##[0:1] !resetOut_b) else $error("flag no reset");
    flag_clr_a: assert property (wdResetFlag && $rose(spiCsn) && !resetOut_b |-> ##[1:2] !wdResetFlag)
        else $error("flag kept");
    fail_stby_a: assert property ($rose(wdResetFlag) |-> ##[0:2] supervisor_standby_mode)
        else $error("fail no standby");
    rel_gap_a: assert property ($rose(resetOut_b) |-> !$past(regulator_output_undervoltage, 100))
        else $error("early release");
endmodule
bind srw_reset_window_watchdog srw_reset_window_watchdog_asserts srw_reset_window_watchdog_asserts_i (.clk, .rst_b,
    .internal_supply_undervoltage, .regulator_output_undervoltage, .spiCsn, .resetOut_b, .supervisor_standby_mode,
    .low_side_switch_one, .low_side_switch_two, .sensorSupplyOn, .led_high_side_driver, .internalSupplyOk,
    .wdResetFlag, .configClear);

// *** verification/srw_spi_host.sv ***
`timescale 1ns/1ps
module srw_spi_host (
    input wire logic clk,
    input wire logic go,
    input wire logic wr,
    input wire logic [3:0] val,
    output logic spiCsn,
    output logic spiWordDone,
    output logic spiPeriodWrite,
    output logic [3:0] spiPeriodValue
);
    initial begin
        spiCsn = 1;
        spiWordDone = 0;
        spiPeriodWrite = 0;
        spiPeriodValue = 4'h5;
        forever begin
            @(posedge clk);
            if (go) begin
                @(negedge clk);
                spiCsn = 0;
                spiPeriodValue = val;
                spiPeriodWrite = wr;
                repeat (2) @(negedge clk);
                spiWordDone = 1;
                @(negedge clk);
                spiWordDone = 0;
                @(negedge clk);
                // service timing is the caller's job
                spiCsn = 1;
            end
        end
    end
endmodule

// *** verification/tb_top.sv ***
`timescale 1ns/1ps
module tb_top
    import srw_pkg::*;
;
    logic clk = 0, rst_b = 0, internal_supply_undervoltage = 0, regulator_output_undervoltage = 0, go = 0, wr = 0;
    logic shortDelaySel = 0, low_side_switch_one_req = 0, low_side_switch_two_req = 0, sensorSupplyReq = 0;
    logic led_high_side_driver_req = 0, spiCsn, spiWordDone, spiPeriodWrite, resetOut_b, supervisor_standby_mode;
    logic low_side_switch_one, low_side_switch_two, sensorSupplyOn, led_high_side_driver, internalSupplyOk;
    logic wdResetFlag, configClear, wdActive, lowPowerReq = 0, supervisor_stop_mode = 0, wdKeepEnable = 0;
    logic ccCurrentBelowThreshold = 0;
    logic [3:0] val = 4'h0, spiPeriodValue, pv;
    logic [31:0] lfsr = 32'h6977;
    int error_cnt = 0, total_checks = 0, n, h;
    initial forever #5 clk = ~clk;
    srw_spi_host srw_spi_host_i (.clk, .go, .wr, .val, .spiCsn, .spiWordDone, .spiPeriodWrite, .spiPeriodValue);
    srw_reset_window_watchdog srw_reset_window_watchdog_i (.clk, .rst_b, .internal_supply_undervoltage,
        .regulator_output_undervoltage, .spiCsn, .spiWordDone, .spiPeriodWrite, .spiPeriodValue, .shortDelaySel,
        .lowPowerReq, .supervisor_stop_mode, .wdKeepEnable, .ccCurrentBelowThreshold,
        .low_side_switch_one_req, .low_side_switch_two_req, .sensorSupplyReq, .led_high_side_driver_req,
        .resetOut_b, .supervisor_standby_mode, .low_side_switch_one, .low_side_switch_two, .sensorSupplyOn,
        .led_high_side_driver, .internalSupplyOk, .wdResetFlag, .configClear, .wdActive);
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // closed or open window length in clk cycles for a period field value
    function automatic int half_cyc(input int p);
        return (p + 1) * PERIOD_UNIT_TICKS / 2 * OSC_DIV;
    endfunction
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic conclude();
        if (error_cnt == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic waitRel(input logic lvl, input int lim);
        n = 0;
        while (resetOut_b !== lvl && n < lim) begin
            @(negedge clk);
            n++;
        end
        if (n >= lim) begin
            error_cnt++;
            conclude();
        end
    endtask
    // one whole word; loads get fresh random requests, the top one always on
    task automatic frame(input logic w, input logic [3:0] p);
        @(negedge clk);
        lfsr = lfsr_next(lfsr);
        {low_side_switch_one_req, low_side_switch_two_req, sensorSupplyReq, led_high_side_driver_req} = lfsr[3:0] | 4'h8;
        wr = w;
        val = w ? p : lfsr[7:4];
        go = 1;
        @(negedge clk);
        go = 0;
        repeat (6) @(negedge clk);
    endtask
    initial begin
        lfsr = lfsr_next(lfsr);
        pv = {2'h0, lfsr[1:0]};
        h = half_cyc(pv);
        repeat (16) @(negedge clk);
        rst_b = 1;
        waitRel(1, (POR_DELAY_TICKS + 8) * OSC_DIV);
        chk("por delay", n >= POR_DELAY_TICKS * OSC_DIV, 1);
        chk("standby", supervisor_standby_mode, 1);
        lowPowerReq = 1;
        repeat (3) @(negedge clk);
        chk("wd parked", wdActive, 0);
        supervisor_stop_mode = 1;
        repeat (3) @(negedge clk);
        chk("wd stop current", wdActive, 1);
        ccCurrentBelowThreshold = 1;
        repeat (3) @(negedge clk);
        chk("wd stop off", wdActive, 0);
        wdKeepEnable = 1;
        repeat (3) @(negedge clk);
        chk("wd kept", wdActive, 1);
        {lowPowerReq, supervisor_stop_mode, wdKeepEnable, ccCurrentBelowThreshold} = 4'h0;
        shortDelaySel = 1;
        frame(1, pv);
        chk("active", supervisor_standby_mode, 0);
        frame(0, 4'h0);
        repeat (h + h / 2 - 16) @(negedge clk);
        chk("no trigger reset", resetOut_b, 1);
        chk("load on", led_high_side_driver, 1);
        frame(1, pv);
        repeat (h / 2) @(negedge clk);
        frame(1, pv);
        waitRel(0, 50);
        chk("wd flag", wdResetFlag, 1);
        chk("standby", supervisor_standby_mode, 1);
        chk("loads", {low_side_switch_one, low_side_switch_two, sensorSupplyOn, led_high_side_driver}, 0);
        frame(0, 4'h0);
        chk("flag clear", wdResetFlag, 0);
        waitRel(1, (SHORT_DELAY_TICKS + 8) * OSC_DIV);
        chk("short delay", n >= SHORT_DELAY_TICKS * OSC_DIV - 16, 1);
        frame(1, pv);
        repeat (16) @(negedge clk);
        chk("long open", resetOut_b, 1);
        regulator_output_undervoltage = 1;
        repeat (2 * OSC_DIV) @(negedge clk);
        regulator_output_undervoltage = 0;
        repeat (2) @(negedge clk);
        chk("uv glitch", resetOut_b, 1);
        regulator_output_undervoltage = 1;
        repeat ((FILTER_TICKS + 3) * OSC_DIV) @(negedge clk);
        chk("cc reset", resetOut_b, 0);
        chk("cc no flag", wdResetFlag, 0);
        regulator_output_undervoltage = 0;
        waitRel(1, (SHORT_DELAY_TICKS + 8) * OSC_DIV);
        chk("cc delay", n >= SHORT_DELAY_TICKS * OSC_DIV, 1);
        internal_supply_undervoltage = 1;
        repeat (3) @(negedge clk);
        chk("supply reset", resetOut_b, 0);
        chk("cfg clear", {configClear, internalSupplyOk}, 2'h2);
        internal_supply_undervoltage = 0;
        conclude();
    end
endmodule
